//--- rtl/pcx_pkg.sv
// Constants, opcodes and carrier types for the peripheral control decoder.
// Assumes 16-bit instruction words; 8-bit codes sit in bits 15:8, 7-bit codes in bits 15:9.
package pcx_pkg;

   // ==========================================================
   // Instruction decode
   localparam int INSTR_W = 16;
   localparam logic [7:0] OP_IEF = 8'h29;
   localparam logic [7:0] OP_LCD_DC_OUTPUT_TYPE = 8'h07;
   localparam logic [7:0] OP_MFP = 8'h12;
   localparam logic [6:0] OP_LCD_DATA_RAM_ACC = 7'h03;
   localparam logic [6:0] OP_LCD_DATA_RAM_WR = 7'h12;
   localparam logic [6:0] OP_LCD_DATA_RAM_IMM = 7'h02;
   localparam logic [3:0] LCD_DATA_RAM_ACC_TAIL = 4'h0;

   // ==========================================================
   // Register layout and reset values
   localparam logic [7:0] IEF_VALID_MASK = 8'h97;
   localparam logic [7:0] IEF_RESET = 8'h00;
   localparam logic [7:0] LCD_DC_OUTPUT_TYPE_RESET = 8'h00;
   localparam logic [7:0] MFP_RESET = 8'h00;
   localparam logic [3:0] LCD_DATA_RAM_RESET = 4'h0;
   localparam int LCD_DATA_RAM_DEPTH = 32;
   localparam int IEF_DIV1_BIT = 4;

   // ==========================================================
   // Pulse generator divider taps
   localparam int DIV_W = 15;
   localparam int TAP_256 = 7;
   localparam int TAP_512 = 8;
   localparam int TAP_4096 = 11;
   localparam int TAP_8192 = 12;
   localparam int TAP_16384 = 13;
   localparam int TAP_32768 = 14;
   localparam int TAP_F16 = 3;
   localparam int TAP_F8 = 2;
   localparam logic [1:0] BASE_LOW = 2'h0;
   localparam logic [1:0] BASE_HIGH = 2'h1;
   localparam logic [1:0] BASE_F16 = 2'h2;
   localparam logic [1:0] BASE_F8 = 2'h3;

   // ==========================================================
   // Interrupt sources, laid out like the enable flags
   typedef struct packed {
      logic tmr1;
      logic rsv6;
      logic rsv5;
      logic div1;
      logic rsv3;
      logic port;
      logic tmr0;
      logic div0;
   } pcx_irq_src_type;

endpackage

//--- rtl/pcx_mfp_gen.sv
// Modulation pulse generator: divider taps, base select, Timer 1 bypass.
// Assumes selection and mode come from registers on the same clock.
`timescale 1ns/1ps
module pcx_mfp_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] sel,
   input wire logic mode_timer1,
   input wire logic timer1_freq,
   output logic mfp_out
);
   import pcx_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic out;
   } pcx_mfp_state_type;

   pcx_mfp_state_type q, d;
   logic [5:0] taps;
   logic base;

   // ==========================================================
   // Waveform
   always_comb begin
      d = q;
      taps = {q.cnt[TAP_32768], q.cnt[TAP_16384], q.cnt[TAP_8192],
              q.cnt[TAP_4096], q.cnt[TAP_512], q.cnt[TAP_256]};
      case (sel[7:6])
         BASE_LOW: base = 1'b0;
         BASE_HIGH: base = 1'b1;
         BASE_F16: base = q.cnt[TAP_F16];
         BASE_F8: base = q.cnt[TAP_F8];
         default: base = 1'b0;
      endcase
      if (ce) begin
         d.cnt = q.cnt + 15'h0001;
         // Several taps at once are ORed; unspecified combination
         if (mode_timer1) begin
            d.out = timer1_freq;
         end else begin
            d.out = base | (|(taps & sel[5:0]));
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign mfp_out = q.out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_timer1_bypass: assert property (
      ce && mode_timer1 |=> mfp_out == $past(timer1_freq))
      else $error("MFP pin not following Timer 1");
   a_static_high: assert property (
      ce && !mode_timer1 && sel == 8'h40 |=> mfp_out)
      else $error("MFP high level not delivered");
   a_static_low: assert property (
      ce && !mode_timer1 && sel == 8'h00 |=> !mfp_out)
      else $error("MFP low level not delivered");
endmodule

//--- rtl/pcx_periph_exec.sv
// Executes peripheral control instructions: enables, LCD type, LCD RAM,
// pulse generator. Assumes the core drives one instruction per valid cycle
// and returns the working register selected by WREG_SEL combinationally.
`timescale 1ns/1ps
module pcx_periph_exec #(
   parameter bit EXT_PIN_BODY = 1'b0
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic INSTR_VALID,
   input wire logic [pcx_pkg::INSTR_W-1:0] INSTR,
   input wire logic [3:0] ACC,
   output logic [3:0] WREG_SEL,
   input wire logic [3:0] WREG_DATA,
   input wire pcx_pkg::pcx_irq_src_type IRQ_SRC,
   input wire logic EXT_INT_PIN,
   output logic [7:0] IRQ_ACCEPT,
   output logic [7:0] INTERRUPT_ENABLE_FLAGS,
   output logic [7:0] LCD_DC_OUTPUT_TYPE,
   input wire logic [4:0] LCD_RD_ADDR,
   output logic [3:0] LCD_RD_DATA,
   output logic [7:0] PULSE_GENERATOR_SELECT,
   input wire logic MODE_REGISTER_ONE_BIT2,
   input wire logic TIMER1_FREQ,
   output logic MFP_OUT
);
   import pcx_pkg::*;

   typedef struct packed {
      logic [7:0] interrupt_enable_flags;
      logic [7:0] lcd_dc_output_type;
      logic [7:0] mfp;
      logic [LCD_DATA_RAM_DEPTH-1:0][3:0] ram;
      logic [3:0] rd_data;
      logic [7:0] irq_acc;
      logic [1:0] ext_sync;
      logic ext_prev;
   } pcx_state_type;

   pcx_state_type q, d;
   logic [7:0] events;
   logic [4:0] lcd_addr;
   logic is_ief, is_lcd_dc_output_type, is_mfp, is_acc, is_wr, is_imm;

   // ==========================================================
   // Decode
   assign lcd_addr = INSTR[8:4];
   assign WREG_SEL = INSTR[3:0];
   // Output-type load wins where it overlaps a high-address ACC write
   assign is_ief = INSTR[15:8] == OP_IEF;
   assign is_lcd_dc_output_type = INSTR[15:8] == OP_LCD_DC_OUTPUT_TYPE;
   assign is_mfp = INSTR[15:8] == OP_MFP;
   assign is_acc = !is_lcd_dc_output_type && INSTR[15:9] == OP_LCD_DATA_RAM_ACC
                   && INSTR[3:0] == LCD_DATA_RAM_ACC_TAIL;
   assign is_wr = INSTR[15:9] == OP_LCD_DATA_RAM_WR;
   assign is_imm = INSTR[15:9] == OP_LCD_DATA_RAM_IMM;

   // ==========================================================
   // Execute, one instruction per enabled cycle
   always_comb begin
      d = q;
      events = IRQ_SRC;
      if (EXT_PIN_BODY) begin
         // Falling edge, seen only after two synchroniser stages
         events[IEF_DIV1_BIT] = q.ext_prev & ~q.ext_sync[1];
      end
      if (CE) begin
         d.ext_sync = {q.ext_sync[0], EXT_INT_PIN};
         d.ext_prev = q.ext_sync[1];
         d.irq_acc = events & q.interrupt_enable_flags & IEF_VALID_MASK;
         d.rd_data = q.ram[LCD_RD_ADDR];
         if (INSTR_VALID) begin
            if (is_ief) begin
               d.interrupt_enable_flags = INSTR[7:0] & IEF_VALID_MASK;
            end
            if (is_lcd_dc_output_type) begin
               d.lcd_dc_output_type = INSTR[7:0];
            end
            if (is_mfp) begin
               d.mfp = INSTR[7:0];
            end
            if (is_acc) begin
               d.ram[lcd_addr] = ACC;
            end
            if (is_wr) begin
               d.ram[lcd_addr] = WREG_DATA;
            end
            if (is_imm) begin
               d.ram[lcd_addr] = INSTR[3:0];
            end
         end
      end
   end

   // Values persist until rewritten or reset
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         q <= '0;
         q.interrupt_enable_flags <= IEF_RESET;
         q.lcd_dc_output_type <= LCD_DC_OUTPUT_TYPE_RESET;
         q.mfp <= MFP_RESET;
         q.ram <= {LCD_DATA_RAM_DEPTH{LCD_DATA_RAM_RESET}};
      end else begin
         q <= d;
      end
   end

   assign IRQ_ACCEPT = q.irq_acc;
   assign INTERRUPT_ENABLE_FLAGS = q.interrupt_enable_flags;
   assign LCD_DC_OUTPUT_TYPE = q.lcd_dc_output_type;
   assign LCD_RD_DATA = q.rd_data;
   assign PULSE_GENERATOR_SELECT = q.mfp;

   // ==========================================================
   // Pulse generator
   pcx_mfp_gen u_mfp (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .ce(CE),
      .sel(q.mfp),
      .mode_timer1(MODE_REGISTER_ONE_BIT2),
      .timer1_freq(TIMER1_FREQ),
      .mfp_out(MFP_OUT)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence s_ief_load;
      CE && INSTR_VALID && is_ief;
   endsequence

   a_ief_load: assert property (
      s_ief_load |=> q.interrupt_enable_flags == ($past(INSTR[7:0]) & 8'h97))
      else $error("Enable flags not loaded from immediate");
   a_reserved_clear: assert property (
      q.interrupt_enable_flags[3] == 1'b0 && q.interrupt_enable_flags[5] == 1'b0 && q.interrupt_enable_flags[6] == 1'b0
      && IRQ_ACCEPT[6:5] == 2'b00 && !IRQ_ACCEPT[3])
      else $error("Reserved enable position became active");
   a_div0_gated: assert property (
      CE && IRQ_SRC.div0 && !q.interrupt_enable_flags[0] |=> !IRQ_ACCEPT[0])
      else $error("Divider 0 accepted while disabled");
   a_tmr0_pass: assert property (
      CE && IRQ_SRC.tmr0 && q.interrupt_enable_flags[1] |=> IRQ_ACCEPT[1])
      else $error("Timer 0 not accepted while enabled");
   a_port_gated: assert property (
      CE && IRQ_SRC.port != q.interrupt_enable_flags[2] |=> !IRQ_ACCEPT[2])
      else $error("Port change gating wrong");
   a_tmr1_pass: assert property (
      CE && IRQ_SRC.tmr1 && q.interrupt_enable_flags[7] |=> IRQ_ACCEPT[7])
      else $error("Timer 1 not accepted while enabled");
   a_lcd_dc_output_type_load: assert property (
      CE && INSTR_VALID && is_lcd_dc_output_type |=> LCD_DC_OUTPUT_TYPE == $past(INSTR[7:0]))
      else $error("Output type not loaded");
   a_acc_write: assert property (
      CE && INSTR_VALID && is_acc |=> q.ram[$past(lcd_addr)] == $past(ACC))
      else $error("Accumulator nibble not stored");
   a_imm_write: assert property (
      CE && INSTR_VALID && is_imm
      |=> q.ram[$past(lcd_addr)] == $past(INSTR[3:0]))
      else $error("Immediate nibble not stored");
   a_mfp_load: assert property (
      CE && INSTR_VALID && is_mfp
      |=> PULSE_GENERATOR_SELECT == $past(INSTR[7:0]))
      else $error("Pulse generator select not loaded");
   a_frozen: assert property (
      !CE |=> $stable(q.interrupt_enable_flags) && $stable(q.ram) && $stable(q.mfp))
      else $error("State changed while clock enable low");
endmodule

//--- verification/pcx_core_model.sv
// Core stand-in: issues instruction words, serves the working registers.
// Assumes the bench calls issue and idle; drives after falling edges.
`timescale 1ns/1ps
module pcx_core_model (
   input wire logic clk,
   input wire logic [3:0] wreg_sel,
   output logic instr_valid,
   output logic [15:0] instr,
   output logic [3:0] acc,
   output logic [3:0] wreg_data
);
   // ==========================================================
   // Working registers
   // Index-dependent pattern, so a wrong index shows
   assign wreg_data = wreg_sel ^ 4'ha;
   initial begin
      instr_valid = 1'b0;
      instr = 16'h0000;
      acc = 4'h0;
   end
   task automatic issue(input logic [15:0] w, input logic [3:0] a);
      @(negedge clk);
      instr_valid = 1'b1;
      instr = w;
      acc = a;
   endtask
   // Released bus shows the inverse, never the stale word
   task automatic idle();
      @(negedge clk);
      instr_valid = 1'b0;
      instr = ~instr;
      acc = ~acc;
   endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the peripheral control decoder.
// Assumes the core model drives instructions; bench owns other inputs.
`timescale 1ns/1ps
module testbench;
   import pcx_pkg::*;
   // ==========================================================
   // Stimulus and wiring
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic ext_int_pin = 1'b1;
   logic mode_bit2 = 1'b0;
   logic timer1_freq = 1'b0;
   logic [4:0] lcd_rd_addr = 5'h00;
   pcx_irq_src_type irq_src = 8'h00;
   logic instr_valid;
   logic [15:0] instr;
   logic [3:0] acc, wreg_sel, wreg_data, lcd_rd_data;
   logic [7:0] irq_accept, interrupt_enable_flags, lcd_dc_output_type, mfp_sel;
   logic mfp_out;
   int n_mismatch = 0;
   int cmp_count = 0;
   localparam int PER [8] = '{256, 512, 4096, 8192, 16384, 32768, 16, 8};
   localparam logic [7:0] MSEL [8] = '{8'h01, 8'h02, 8'h04, 8'h08,
      8'h10, 8'h20, 8'h80, 8'hc0};
   localparam int IB [5] = '{0, 1, 2, 4, 7};
   // Instr, acc, output kind, read address, expected
   localparam logic [34:0] ROWS [8] = '{
      {16'h29ff, 4'h0, 2'h0, 5'h00, 8'h97},
      {16'h2968, 4'h0, 2'h0, 5'h00, 8'h00},
      {16'h07a5, 4'h0, 2'h1, 5'h00, 8'ha5},
      {16'h1236, 4'h0, 2'h3, 5'h00, 8'h36},
      {16'h06f0, 4'h9, 2'h2, 5'h0f, 8'h09},
      {16'h06f1, 4'h3, 2'h2, 5'h0f, 8'h09},
      {16'h25f3, 4'h0, 2'h2, 5'h1f, 8'h09},
      {16'h040c, 4'h0, 2'h2, 5'h00, 8'h0c}};
   always #2.5 clk_sys = ~clk_sys;
   pcx_core_model core (.clk(clk_sys), .wreg_sel(wreg_sel),
      .instr_valid(instr_valid), .instr(instr), .acc(acc),
      .wreg_data(wreg_data));
   pcx_periph_exec dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
      .INSTR_VALID(instr_valid), .INSTR(instr), .ACC(acc),
      .WREG_SEL(wreg_sel), .WREG_DATA(wreg_data), .IRQ_SRC(irq_src),
      .EXT_INT_PIN(ext_int_pin), .IRQ_ACCEPT(irq_accept),
      .INTERRUPT_ENABLE_FLAGS(interrupt_enable_flags), .LCD_DC_OUTPUT_TYPE(lcd_dc_output_type),
      .LCD_RD_ADDR(lcd_rd_addr), .LCD_RD_DATA(lcd_rd_data),
      .PULSE_GENERATOR_SELECT(mfp_sel),
      .MODE_REGISTER_ONE_BIT2(mode_bit2), .TIMER1_FREQ(timer1_freq),
      .MFP_OUT(mfp_out));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic run(input logic [15:0] w, input logic [3:0] a);
      core.issue(w, a);
      core.idle();
      @(negedge clk_sys);
   endtask
   function automatic logic [7:0] pick(input logic [1:0] k);
      case (k)
         2'h0: pick = interrupt_enable_flags;
         2'h1: pick = lcd_dc_output_type;
         2'h2: pick = {4'h0, lcd_rd_data};
         default: pick = mfp_sel;
      endcase
   endfunction
   // ==========================================================
   // Main sequence
   initial begin
      int ones;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      check({interrupt_enable_flags, lcd_dc_output_type, mfp_sel, irq_accept}, 32'h0000_0000);
      foreach (ROWS[i]) begin
         lcd_rd_addr = ROWS[i][12:8];
         run(ROWS[i][34:19], ROWS[i][18:15]);
         check(pick(ROWS[i][14:13]), ROWS[i][7:0]);
      end
      irq_src = 8'hff;
      foreach (IB[i]) begin
         run({8'h29, 8'h01 << IB[i]}, 4'h0);
         check(irq_accept, 8'h01 << IB[i]);
      end
      ce = 1'b0;
      run(16'h2997, 4'h0);
      ce = 1'b1;
      check(interrupt_enable_flags, 8'h80);
      // Every address, back to back with no idle cycle
      for (int a = 0; a < 32; a++) core.issue({7'h02, a[4:0], a[3:0] ^ 4'h5}, 4'h0);
      core.idle();
      for (int a = 0; a < 32; a++) begin
         lcd_rd_addr = a[4:0];
         @(negedge clk_sys);
         check(lcd_rd_data, a[3:0] ^ 4'h5);
      end
      foreach (PER[i]) begin
         run({8'h12, MSEL[i]}, 4'h0);
         ones = 0;
         repeat (PER[i]) begin
            @(negedge clk_sys);
            if (mfp_out === 1'b1) ones++;
         end
         check(ones, PER[i] / 2);
      end
      run(16'h1240, 4'h0);
      check(mfp_out, 1'b1);
      mode_bit2 = 1'b1;
      for (int k = 0; k < 4; k++) begin
         timer1_freq = k[0] ^ k[1];
         @(negedge clk_sys);
         check(mfp_out, k[0] ^ k[1]);
      end
      rst_n = 1'b0;
      @(negedge clk_sys);
      check({interrupt_enable_flags, lcd_dc_output_type, mfp_sel}, 24'h00_0000);
      rst_n = 1'b1;
      lcd_rd_addr = 5'h01;
      @(negedge clk_sys);
      check(lcd_rd_data, 4'h0);
      give_verdict();
   end
   // Run needs about 62k cycles
   initial begin
      #500000;
      n_mismatch++;
      give_verdict();
   end
endmodule
